// >>> pcs_pkg.sv
package pcs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam logic [15:0] PIN_SEVEN_PAD_ADDR = 16'hF7A2;
	localparam logic [15:0] CLOCK_OUTPUT_PAD_ADDR = 16'hF7A3;
	localparam logic [15:0] SOFT_RESET_ADDR = 16'hF890;
	localparam logic [15:0] PLL_BASE_ADDR = 16'hF000;
	localparam int PLL_WORDS = 7;

	// ----------------------------------------------------------------
	// Pad register field layout
	// ----------------------------------------------------------------
	localparam int PAD_W = 5;
	localparam int PULL_BIT = 4;
	localparam int SLEW_LSB = 2;
	localparam int SLEW_MSB = 3;
	localparam int DRIVE_LSB = 0;
	localparam int DRIVE_MSB = 1;
	localparam logic [4:0] PIN_SEVEN_PAD_RESET = 5'h18;
	localparam logic [4:0] CLOCK_OUTPUT_PAD_RESET = 5'h08;

	// ----------------------------------------------------------------
	// Soft reset register
	// ----------------------------------------------------------------
	localparam int SOFT_BIT = 0;
	localparam logic SOFT_RESET_BIT_RESET = 1'b1;
	localparam logic [15:0] PLL_WORD_RESET = 16'h0000;

	typedef enum logic {
		PCS_NORMAL,
		PCS_SOFT_RESET
	} pcs_mode_type;

endpackage : pcs_pkg

// >>> pcs_pad_soft_reset.sv
`timescale 1ns/1ps
// Contract
// - Pin seven pad: pulldown, slew, drive; reset 0x18
// - Clock output pad: same fields, reset 0x08
// - Soft reset bit 0, active low, resets 1
// - Soft reset returns both pad registers to defaults
// - PLL registers survive soft reset
// - Slave ports and PLL writes work during reset
// - SPI slave mode kept through soft reset
module pcs_pad_soft_reset #(
	parameter int PLL_COUNT = pcs_pkg::PLL_WORDS
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [pcs_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [pcs_pkg::DATA_W-1:0] REG_WDATA,
	output logic [pcs_pkg::DATA_W-1:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic SPI_MODE_SELECT,
	output logic SPI_MODE,
	output logic SOFT_RESET_ACTIVE,
	output logic PIN_SEVEN_PULLDOWN_ENABLE,
	output logic [1:0] PIN_SEVEN_SLEW_SELECT,
	output logic [1:0] PIN_SEVEN_DRIVE_SELECT,
	output logic CLOCK_OUTPUT_PULLDOWN_ENABLE,
	output logic [1:0] CLOCK_OUTPUT_SLEW_SELECT,
	output logic [1:0] CLOCK_OUTPUT_DRIVE_SELECT,
	output logic [pcs_pkg::DATA_W-1:0] PLL_CONTROL_WORD_A
);
	import pcs_pkg::*;

	// The word index is three bits wide, so eight words at the most
	if (PLL_COUNT < 1 || PLL_COUNT > 8) begin : g_bad_count
		$error("PLL_COUNT must be 1 to 8");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [PAD_W-1:0] pad_field(
		input logic [DATA_W-1:0] d);
		pad_field = d[PAD_W-1:0];
	endfunction : pad_field

	function automatic logic [DATA_W-1:0] widen_pad(
		input logic [PAD_W-1:0] p);
		widen_pad = {{(DATA_W-PAD_W){1'b0}}, p};
	endfunction : widen_pad

	function automatic logic is_pll(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - PLL_BASE_ADDR;
		is_pll = (a >= PLL_BASE_ADDR) && (off < ADDR_W'(PLL_COUNT));
	endfunction : is_pll

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pcs_mode_type mode;
	logic [PAD_W-1:0] pin_seven_pad;
	logic [PAD_W-1:0] clock_output_pad;
	logic [DATA_W-1:0] pll_word [PLL_COUNT];
	logic spi_mode;
	logic soft_active;
	logic wr_pad7;
	logic wr_clk_pad;
	logic wr_soft;
	logic [ADDR_W-1:0] pll_off;
	logic [2:0] pll_idx;

	assign soft_active = (mode == PCS_SOFT_RESET);
	assign wr_pad7 = REG_WR && (REG_ADDR == PIN_SEVEN_PAD_ADDR);
	assign wr_clk_pad = REG_WR && (REG_ADDR == CLOCK_OUTPUT_PAD_ADDR);
	assign wr_soft = REG_WR && (REG_ADDR == SOFT_RESET_ADDR);
	assign pll_off = REG_ADDR - PLL_BASE_ADDR;
	assign pll_idx = pll_off[2:0];

	// ----------------------------------------------------------------
	// Soft reset control
	// ----------------------------------------------------------------
	// Stays in soft reset until software writes the bit back to one,
	// so the bit itself must remain writable while both pad registers are
	// held at their defaults.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode <= PCS_NORMAL;
		end else if (wr_soft) begin
			case (REG_WDATA[SOFT_BIT])
				1'b0: mode <= PCS_SOFT_RESET;
				1'b1: mode <= PCS_NORMAL;
				default: mode <= PCS_NORMAL;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pad configuration registers
	// ----------------------------------------------------------------
	// Only the low field bits are stored; reserved bits have no flops.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_seven_pad <= PIN_SEVEN_PAD_RESET;
		end else if (soft_active) begin
			pin_seven_pad <= PIN_SEVEN_PAD_RESET;
		end else if (wr_pad7) begin
			pin_seven_pad <= pad_field(REG_WDATA);
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			clock_output_pad <= CLOCK_OUTPUT_PAD_RESET;
		end else if (soft_active) begin
			clock_output_pad <= CLOCK_OUTPUT_PAD_RESET;
		end else if (wr_clk_pad) begin
			clock_output_pad <= pad_field(REG_WDATA);
		end
	end

	// ----------------------------------------------------------------
	// PLL words, kept across soft reset
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < PLL_COUNT; i++)
				pll_word[i] <= PLL_WORD_RESET;
		end else if (REG_WR && is_pll(REG_ADDR)) begin
			pll_word[pll_idx] <= REG_WDATA;
		end
	end

	// ----------------------------------------------------------------
	// Control port mode
	// ----------------------------------------------------------------
	// Only the pin reset clears SPI mode; soft reset has no path here.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			spi_mode <= 1'b0;
		end else if (SPI_MODE_SELECT) begin
			spi_mode <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Reads are served during soft reset too; the pad registers show default values from its second cycle on.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			REG_RDATA <= '0;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				if (REG_ADDR == PIN_SEVEN_PAD_ADDR)
					REG_RDATA <= widen_pad(pin_seven_pad);
				else if (REG_ADDR == CLOCK_OUTPUT_PAD_ADDR)
					REG_RDATA <= widen_pad(clock_output_pad);
				else if (REG_ADDR == SOFT_RESET_ADDR)
					REG_RDATA <= {15'h0000, ~soft_active};
				else if (is_pll(REG_ADDR))
					REG_RDATA <= pll_word[pll_idx];
				else
					REG_RDATA <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign SPI_MODE = spi_mode;
	assign SOFT_RESET_ACTIVE = soft_active;
	assign PIN_SEVEN_PULLDOWN_ENABLE = pin_seven_pad[PULL_BIT];
	assign PIN_SEVEN_SLEW_SELECT = pin_seven_pad[SLEW_MSB:SLEW_LSB];
	assign PIN_SEVEN_DRIVE_SELECT = pin_seven_pad[DRIVE_MSB:DRIVE_LSB];
	assign CLOCK_OUTPUT_PULLDOWN_ENABLE = clock_output_pad[PULL_BIT];
	assign CLOCK_OUTPUT_SLEW_SELECT = clock_output_pad[SLEW_MSB:SLEW_LSB];
	assign CLOCK_OUTPUT_DRIVE_SELECT =
		clock_output_pad[DRIVE_MSB:DRIVE_LSB];
	assign PLL_CONTROL_WORD_A = pll_word[0];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence enter_soft;
		wr_soft && !REG_WDATA[SOFT_BIT];
	endsequence

	sequence pad7_write_normal;
		wr_pad7 && !soft_active && !wr_soft;
	endsequence

	a_pad7_write: assert property (@(posedge CLK) disable iff (!RST_B)
		pad7_write_normal |=> pin_seven_pad == $past(REG_WDATA[4:0]))
		else $error("pin seven pad write lost");

	a_clk_pad_default: assert property (@(posedge CLK)
		disable iff (!RST_B)
		enter_soft |=> ##1 clock_output_pad == CLOCK_OUTPUT_PAD_RESET)
		else $error("clock output pad not back to default");

	a_soft_enter: assert property (@(posedge CLK) disable iff (!RST_B)
		enter_soft |=> SOFT_RESET_ACTIVE)
		else $error("soft reset not entered");

	a_soft_exit: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_soft && REG_WDATA[SOFT_BIT] |=> !SOFT_RESET_ACTIVE)
		else $error("soft reset not left");

	a_pad7_held: assert property (@(posedge CLK) disable iff (!RST_B)
		soft_active ##1 soft_active |-> pin_seven_pad == PIN_SEVEN_PAD_RESET)
		else $error("pin seven pad not held at default");

	a_pll_kept: assert property (@(posedge CLK) disable iff (!RST_B)
		soft_active && !(REG_WR && is_pll(REG_ADDR)) |=>
		$stable(PLL_CONTROL_WORD_A))
		else $error("pll word disturbed by soft reset");

	a_pll_soft_write: assert property (@(posedge CLK)
		disable iff (!RST_B)
		soft_active && REG_WR && REG_ADDR == PLL_BASE_ADDR |=>
		PLL_CONTROL_WORD_A == $past(REG_WDATA))
		else $error("pll write refused during soft reset");

	a_spi_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
		SPI_MODE |=> SPI_MODE [*2])
		else $error("spi mode dropped");

	a_reserved_zero: assert property (@(posedge CLK)
		disable iff (!RST_B)
		REG_RD && (REG_ADDR == PIN_SEVEN_PAD_ADDR ||
		REG_ADDR == CLOCK_OUTPUT_PAD_ADDR ||
		REG_ADDR == SOFT_RESET_ADDR) |=>
		REG_RVALID && REG_RDATA[15:5] == 11'h000)
		else $error("reserved bits not zero");

	a_rvalid_pulse: assert property (@(posedge CLK) disable iff (!RST_B)
		!REG_RD |=> !REG_RVALID)
		else $error("read answer without read request");

endmodule : pcs_pad_soft_reset

// >>> pcs_host.sv
`timescale 1ns/1ps
module pcs_host (
	input wire logic CLK,
	input wire logic [15:0] RDATA,
	input wire logic RVALID,
	output logic [15:0] ADDR,
	output logic WR,
	output logic RD,
	output logic [15:0] WDATA
);
	initial begin
		ADDR = 16'h0000;
		WDATA = 16'h0000;
		WR = 1'b0;
		RD = 1'b0;
	end
	task automatic put(input logic [15:0] a, d, input logic w);
		@(posedge CLK);
		#1;
		ADDR = a;
		WDATA = d;
		WR = w;
		RD = !w;
		@(posedge CLK);
		#1;
		// Idle lines show the inverse so no stale value looks valid
		ADDR = ~a;
		WDATA = ~d;
		WR = 1'b0;
		RD = 1'b0;
	endtask : put
	task automatic wr_reg(input logic [15:0] a, d);
		put(a, d, 1'b1);
	endtask : wr_reg
	task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
		put(a, 16'h0000, 1'b0);
		d = RVALID ? RDATA : 16'hDEAD;
	endtask : rd_reg
endmodule : pcs_host

// >>> test_pad_config_and_soft_reset.sv
`timescale 1ns/1ps
module test_pad_config_and_soft_reset;
	import pcs_pkg::*;
	logic CLK, RST_B, SPI_SEL, WR, RD, RVALID, SPI_MODE, SOFT, P7_PULL, CK_PULL;
	logic [1:0] P7_SLEW, P7_DRV, CK_SLEW, CK_DRV;
	logic [15:0] ADDR, WDATA, RDATA, PLL, d;
	int n_mismatch, compares;
	pcs_host host (.CLK(CLK), .RDATA(RDATA), .RVALID(RVALID), .ADDR(ADDR),
		.WR(WR), .RD(RD), .WDATA(WDATA));
	pcs_pad_soft_reset #(.PLL_COUNT(7)) uut (.CLK(CLK), .RST_B(RST_B),
		.REG_ADDR(ADDR), .REG_WR(WR), .REG_RD(RD), .REG_WDATA(WDATA),
		.REG_RDATA(RDATA), .REG_RVALID(RVALID), .SPI_MODE_SELECT(SPI_SEL),
		.SPI_MODE(SPI_MODE), .SOFT_RESET_ACTIVE(SOFT),
		.PIN_SEVEN_PULLDOWN_ENABLE(P7_PULL), .PIN_SEVEN_SLEW_SELECT(P7_SLEW),
		.PIN_SEVEN_DRIVE_SELECT(P7_DRV), .CLOCK_OUTPUT_PULLDOWN_ENABLE(CK_PULL),
		.CLOCK_OUTPUT_SLEW_SELECT(CK_SLEW), .CLOCK_OUTPUT_DRIVE_SELECT(CK_DRV),
		.PLL_CONTROL_WORD_A(PLL));
	// ----------------------------------------------------------------
	// Clock, compare and closing
	// ----------------------------------------------------------------
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	task automatic chk(input string what, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rchk(input string what, input logic [15:0] a, exp);
		host.rd_reg(a, d);
		chk(what, exp, d);
	endtask : rchk
	task automatic end_sim;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial begin
		#200us;
		n_mismatch++;
		end_sim();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		RST_B = 1'b0;
		SPI_SEL = 1'b0;
		repeat (2) @(posedge CLK);
		#1;
		RST_B = 1'b1;
		chk("pad7 pins", 16'h0018, {11'h0, P7_PULL, P7_SLEW, P7_DRV});
		chk("clk pins", 16'h0008, {11'h0, CK_PULL, CK_SLEW, CK_DRV});
		rchk("pad7", 16'hF7A2, 16'h0018);
		rchk("clkpad", 16'hF7A3, 16'h0008);
		rchk("soft", 16'hF890, 16'h0001);
		rchk("unmapped", 16'hF7A4, 16'h0000);
		$display("test reset_values done");
		for (int i = 0; i < 4; i++) begin
			host.wr_reg(16'hF7A2, 16'hFFE0 | 16'(i * 5));
			chk("pad7 pins", 16'(i * 5), {11'h0, P7_PULL, P7_SLEW, P7_DRV});
			host.wr_reg(16'hF7A3, 16'hFFF0 | 16'(15 - i * 5 % 16));
			rchk("clkpad", 16'hF7A3, 16'h0010 | 16'(15 - i * 5 % 16));
		end
		rchk("soft", 16'hF890, 16'h0001);
		$display("test pad_fields done");
		@(posedge CLK);
		#1;
		SPI_SEL = 1'b1;
		@(posedge CLK);
		#1;
		SPI_SEL = 1'b0;
		host.wr_reg(16'hF000, 16'h1234);
		host.wr_reg(16'hF890, 16'hFFFE);
		chk("soft flag", 16'h0001, {15'h0, SOFT});
		@(posedge CLK);
		#1;
		chk("pad7 pins", 16'h0018, {11'h0, P7_PULL, P7_SLEW, P7_DRV});
		chk("clk pins", 16'h0008, {11'h0, CK_PULL, CK_SLEW, CK_DRV});
		rchk("soft", 16'hF890, 16'h0000);
		host.wr_reg(16'hF7A2, 16'h0003);
		rchk("pad7", 16'hF7A2, 16'h0018);
		chk("pll kept", 16'h1234, PLL);
		host.wr_reg(16'hF000, 16'hABCD);
		host.wr_reg(16'hF006, 16'h00C3);
		rchk("pll word", 16'hF000, 16'hABCD);
		rchk("pll last", 16'hF006, 16'h00C3);
		chk("spi mode", 16'h0001, {15'h0, SPI_MODE});
		host.wr_reg(16'hF890, 16'h0001);
		chk("soft flag", 16'h0000, {15'h0, SOFT});
		chk("spi mode", 16'h0001, {15'h0, SPI_MODE});
		chk("pll word", 16'hABCD, PLL);
		rchk("pad7", 16'hF7A2, 16'h0018);
		$display("test soft_reset done");
		// Only the pin reset brings the port back to I2C
		@(posedge CLK);
		#1;
		RST_B = 1'b0;
		@(posedge CLK);
		#1;
		chk("spi mode", 16'h0000, {15'h0, SPI_MODE});
		chk("pll word", 16'h0000, PLL);
		RST_B = 1'b1;
		rchk("pll word", 16'hF000, 16'h0000);
		$display("test pin_reset done");
		end_sim();
	end
endmodule : test_pad_config_and_soft_reset
